// ---- hdl/bcmsr_pkg.sv ----
/*
 * Package for the bus controller message status and retry block: timing
 * figures, retry count encodings, message kinds and the carrier structs.
 * Assumes a 10 MHz reference clock.
 */
package bcmsr_pkg;

	localparam int          CLK_PERIOD_NS      = 100;
	localparam int          MIN_RESP_TIME_NS   = 4000;
	localparam int          DEAD_TIME_NS       = 2000;
	localparam int          MIN_RESP_CYCLES    = (MIN_RESP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          RESP_CNT_W         = 8;
	localparam logic [1:0]  RETRY_NONE         = 2'h0;
	localparam logic [1:0]  RETRY_ONE          = 2'h1;
	localparam logic [1:0]  RETRY_TWO          = 2'h2;
	localparam logic [1:0]  RETRY_MAX          = 2'h2;
	localparam int          MASK_LO            = 9;
	localparam int          MASK_HI            = 14;
	localparam int          CFG_RETRY_EN_BIT   = 12;
	localparam int          CFG_RETRY_STAT_BIT = 8;
	localparam int          CFG_GAP_CHECK_BIT  = 1;
	localparam int          CTRL_RETRY_EN_BIT  = 8;
	localparam logic [4:0]  RT_ADDR_RESET      = 5'h00;

	typedef enum logic [2:0] {
		BCMSR_KIND_BC_TO_RT  = 3'h0,
		BCMSR_KIND_RT_TO_BC  = 3'h1,
		BCMSR_KIND_RT_TO_RT  = 3'h2,
		BCMSR_KIND_MC_NODATA = 3'h3,
		BCMSR_KIND_MC_TX_DAT = 3'h4,
		BCMSR_KIND_MC_RX_DAT = 3'h5
	} bcmsr_kind_type;

	// One attempt's outcome, presented by the message engine with attempt_done.
	typedef struct packed {
		bcmsr_kind_type kind;
		logic           complete;
		logic           format_error;
		logic           other_error;
		logic           status_valid;
		logic [4:0]     status_rt_addr;
		logic [10:0]    status_bits;
	} bcmsr_attempt_type;

	// Status bits written back for the message when it ends.
	typedef struct packed {
		logic       retry_count_hi;
		logic       retry_count_lo;
		logic       good_transmit_block;
		logic       wrong_addr_or_gap;
		logic       masked_status_set;
	} bcmsr_status_type;

endpackage : bcmsr_pkg

// ---- hdl/bcmsr_top.sv ----
/*
 * Message status and retry decision logic for the bus controller.
 * Assumes the message engine (same clock) pulses cmd_start_in when a command
 * word is sent, resp_sync_in at a response mid-sync, and attempt_done_in once
 * per attempt with its outcome; this block answers retry or final status.
 */
`timescale 1ns/100ps
// Summary of operation
// - A message is retried on a format error when config bit 12 and control word bit 8 are set.
// - A message is retried on masked status set when config bits 12 and 8 and control bit 8 are set.
// - The two-bit retry count reports 00, 01 or 10 retries, and 11 is never produced.
// - Good transmit block is set when an error-free RT-to-BC or transmit mode code with data completes, or an RT-to-RT completes with its transmit part good.
// - Good transmit block is clear for BC-to-RT, mode codes without data and incomplete or invalid messages.
// - On RT-to-RT, good transmit block may stand together with the later error flag.
// - Wrong address or gap is set when the status word address differs from the commanded address.
// - With gap check on, wrong address or gap is set when response time is under 4 us (2 us dead time).
// - Masked status set is flagged when a status bit is set whose mask bit in control bits 14-9 is clear.
module bcmsr_top
	import bcmsr_pkg::*;
#(
	parameter int MIN_RESP_CNT = MIN_RESP_CYCLES
) (
	input  wire logic              ref_clk_in,
	input  wire logic              nrst_in,
	input  wire logic [15:0]       bc_config_in,
	input  wire logic [15:0]       msg_ctrl_in,
	input  wire logic [4:0]        cmd_rt_addr_in,
	input  wire logic              cmd_start_in,
	input  wire logic              resp_sync_in,
	input  wire logic              tx_part_ok_in,
	input  wire logic              attempt_done_in,
	input  wire bcmsr_attempt_type attempt_in,
	output logic                   retry_out,
	output logic                   msg_done_out,
	output bcmsr_status_type       status_out
);

	logic [1:0]            retries_r;
	logic [1:0]            retries_nxt;
	logic [RESP_CNT_W-1:0] resp_cnt_r;
	logic [RESP_CNT_W-1:0] resp_cnt_nxt;
	logic                  gap_short_r;
	logic                  gap_short_nxt;
	logic [4:0]            cmd_addr_r;
	logic [4:0]            cmd_addr_nxt;
	logic                  retry_r;
	logic                  done_r;
	bcmsr_status_type      status_r;
	bcmsr_status_type      status_nxt;
	bcmsr_status_type      status_fin;

	// Mask bits 14 down to 9 cover status bits 10 down to 5 one to one; a clear
	// mask bit means that status bit is watched.
	wire logic [5:0] mask_bits      = msg_ctrl_in[MASK_HI:MASK_LO];
	wire logic [5:0] watched_bits   = attempt_in.status_bits[10:5];
	wire logic       mstat_hit      = attempt_in.status_valid
	                                  && |(watched_bits & ~mask_bits);
	wire logic       retry_en       = bc_config_in[CFG_RETRY_EN_BIT]
	                                  && msg_ctrl_in[CTRL_RETRY_EN_BIT];
	wire logic       retry_fe       = retry_en && attempt_in.format_error;
	wire logic       retry_ms       = retry_en && bc_config_in[CFG_RETRY_STAT_BIT]
	                                  && mstat_hit;
	wire logic       can_retry      = (retries_r != RETRY_MAX);
	wire logic       do_retry       = attempt_done_in && (retry_fe || retry_ms) && can_retry;
	wire logic       finish         = attempt_done_in && !do_retry;
	wire logic       addr_bad       = attempt_in.status_valid
	                                  && (attempt_in.status_rt_addr != cmd_addr_r);
	wire logic       gap_bad        = bc_config_in[CFG_GAP_CHECK_BIT] && gap_short_r;
	wire logic       tx_kind        = (attempt_in.kind == BCMSR_KIND_RT_TO_BC)
	                                  || (attempt_in.kind == BCMSR_KIND_MC_TX_DAT);
	wire logic       clean          = attempt_in.complete && !attempt_in.format_error
	                                  && !attempt_in.other_error;
	// RT-to-RT judges only its transmit part, so a later receive-side error
	// can stand beside the good flag.
	wire logic       rtrt_good      = (attempt_in.kind == BCMSR_KIND_RT_TO_RT)
	                                  && attempt_in.complete && tx_part_ok_in;
	wire logic       good_blk       = (tx_kind && clean) || rtrt_good;
	// The count is one at the first edge after the command, so at a response
	// sync it holds the whole cycles elapsed, which is what the gap rule measures.
	// It saturates instead of wrapping, so MIN_RESP_CNT must stay below its top.
	wire logic       resp_cnt_full  = (resp_cnt_r == '1);
	wire logic       resp_early     = resp_cnt_r < RESP_CNT_W'(MIN_RESP_CNT);
	wire logic       sync_short     = resp_sync_in && resp_early;

	// Fields of the status written when the message ends.
	wire logic       fin_count_hi   = retries_r[1];
	wire logic       fin_count_lo   = retries_r[0];
	wire logic       fin_good       = good_blk;
	wire logic       fin_wag        = addr_bad || gap_bad;
	wire logic       fin_masked     = mstat_hit;

	assign retries_nxt   = do_retry ? retries_r + 2'h1 : (finish ? RETRY_NONE : retries_r);
	assign resp_cnt_nxt  = cmd_start_in  ? RESP_CNT_W'(1)
	                     : resp_cnt_full ? resp_cnt_r
	                     :                 resp_cnt_r + RESP_CNT_W'(1);
	assign gap_short_nxt = cmd_start_in ? 1'b0 : (gap_short_r || sync_short);
	assign cmd_addr_nxt  = cmd_start_in ? cmd_rt_addr_in : cmd_addr_r;
	assign status_fin    = {fin_count_hi, fin_count_lo, fin_good, fin_wag, fin_masked};
	// Status holds between message ends, so a reader always sees the last message.
	assign status_nxt    = finish ? status_fin : status_r;

	// Every state element is one reset register, so all share one reset style.
	bcmsr_dreg #(
		.WIDTH       (2),
		.RESET_VALUE (RETRY_NONE)
	) i_bcmsr_dreg_retries (
		.ref_clk_in (ref_clk_in),
		.nrst_in    (nrst_in),
		.d_in       (retries_nxt),
		.q_out      (retries_r)
	);

	bcmsr_dreg #(
		.WIDTH       (RESP_CNT_W),
		.RESET_VALUE ('0)
	) i_bcmsr_dreg_resp_cnt (
		.ref_clk_in (ref_clk_in),
		.nrst_in    (nrst_in),
		.d_in       (resp_cnt_nxt),
		.q_out      (resp_cnt_r)
	);

	bcmsr_dreg #(
		.WIDTH       (1),
		.RESET_VALUE (1'b0)
	) i_bcmsr_dreg_gap_short (
		.ref_clk_in (ref_clk_in),
		.nrst_in    (nrst_in),
		.d_in       (gap_short_nxt),
		.q_out      (gap_short_r)
	);

	bcmsr_dreg #(
		.WIDTH       (5),
		.RESET_VALUE (RT_ADDR_RESET)
	) i_bcmsr_dreg_cmd_addr (
		.ref_clk_in (ref_clk_in),
		.nrst_in    (nrst_in),
		.d_in       (cmd_addr_nxt),
		.q_out      (cmd_addr_r)
	);

	// The answer is registered, so it follows the attempt by exactly one edge.
	bcmsr_dreg #(
		.WIDTH       (1),
		.RESET_VALUE (1'b0)
	) i_bcmsr_dreg_retry (
		.ref_clk_in (ref_clk_in),
		.nrst_in    (nrst_in),
		.d_in       (do_retry),
		.q_out      (retry_r)
	);

	bcmsr_dreg #(
		.WIDTH       (1),
		.RESET_VALUE (1'b0)
	) i_bcmsr_dreg_done (
		.ref_clk_in (ref_clk_in),
		.nrst_in    (nrst_in),
		.d_in       (finish),
		.q_out      (done_r)
	);

	// Status changes only at a message end, in the same cycle as the done pulse.
	bcmsr_dreg #(
		.WIDTH       ($bits(bcmsr_status_type)),
		.RESET_VALUE ('0)
	) i_bcmsr_dreg_status (
		.ref_clk_in (ref_clk_in),
		.nrst_in    (nrst_in),
		.d_in       (status_nxt),
		.q_out      (status_r)
	);

	assign retry_out    = retry_r;
	assign msg_done_out = done_r;
	assign status_out   = status_r;

endmodule : bcmsr_top

// One register with asynchronous reset to a fixed value.
// Keeping every flip-flop in this shape leaves no room for a reset branch
// that reads anything but a constant.
module bcmsr_dreg
	import bcmsr_pkg::*;
#(
	parameter int               WIDTH       = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input  wire logic             ref_clk_in,
	input  wire logic             nrst_in,
	input  wire logic [WIDTH-1:0] d_in,
	output logic      [WIDTH-1:0] q_out
);

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			q_out <= RESET_VALUE;
		end else begin
			q_out <= d_in;
		end
	end

endmodule : bcmsr_dreg

// ---- tb/bcmsr_engine.sv ----
/* Message engine model: command, response sync and attempt pulses.
   Assumes run() is called at a falling clock edge. */
`timescale 1ns/100ps
module bcmsr_engine
	import bcmsr_pkg::*;
(
	input	wire logic	clk_in,
	output	logic	cmd_start_out,
	output	logic	resp_sync_out,
	output	logic	done_out,
	output	bcmsr_attempt_type	att_out
);
	initial {cmd_start_out, resp_sync_out, done_out, att_out} = '0;
	// Outcome stands only with done; afterwards it is inverted so a stale outcome is never used.
	task run(input bcmsr_attempt_type a, input int gap);
		cmd_start_out = 1'b1;
		@(negedge clk_in) cmd_start_out = 1'b0;
		repeat (gap - 1) @(negedge clk_in);
		resp_sync_out = 1'b1;
		@(negedge clk_in) resp_sync_out = 1'b0;
		{done_out, att_out} = {1'b1, a};
		@(negedge clk_in) {done_out, att_out} = {1'b0, ~a};
	endtask : run
endmodule : bcmsr_engine

// ---- tb/bcmsr_properties.sv ----
/* Checker for bcmsr_top.
   Sees only the top ports; one clock, asynchronous active-low reset. */
`timescale 1ns/100ps
module bcmsr_properties
	import bcmsr_pkg::*;
(
	input	wire logic	ref_clk_in,
	input	wire logic	nrst_in,
	input	wire logic [15:0]	bc_config_in,
	input	wire logic [15:0]	msg_ctrl_in,
	input	wire logic	attempt_done_in,
	input	wire bcmsr_attempt_type	attempt_in,
	input	wire logic	retry_out,
	input	wire logic	msg_done_out,
	input	wire bcmsr_status_type	status_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!nrst_in);
	wire	clean = attempt_in.complete & ~attempt_in.format_error & ~attempt_in.other_error;
	wire	masked = attempt_in.status_valid & |(attempt_in.status_bits[10:5] & ~msg_ctrl_in[14:9]);
	wire	start = attempt_done_in & ~bc_config_in[12];
	sequence s_final; !retry_out && msg_done_out; endsequence
	a_one_answer: assert property (attempt_done_in |=> retry_out != msg_done_out)
		else $error("answer not exactly one of retry and done");
	a_answer_cause: assert property ((retry_out || msg_done_out) |-> $past(attempt_done_in))
		else $error("answer without attempt");
	a_count_legal: assert property (msg_done_out |-> status_out[4:3] != 2'h3)
		else $error("retry count code 11 reported");
	a_no_retry_off: assert property (start |=> s_final)
		else $error("retry while retries are off");
	a_status_off: assert property (attempt_done_in && masked && !bc_config_in[8] && clean
		|=> !retry_out)
		else $error("status retry while status retry is off");
	a_good_clean: assert property (start && clean && attempt_in.kind == BCMSR_KIND_RT_TO_BC
		|=> s_final ##0 status_out.good_transmit_block)
		else $error("good block flag missing");
	a_good_clear: assert property (msg_done_out && $past(attempt_in.kind) inside
		{BCMSR_KIND_BC_TO_RT, BCMSR_KIND_MC_NODATA} |-> !status_out.good_transmit_block)
		else $error("good block flag on a receive message");
	a_mask_flag: assert property (start && masked |=> status_out.masked_status_set)
		else $error("masked status flag missing");
endmodule : bcmsr_properties
bind bcmsr_top bcmsr_properties i_bcmsr_properties (.ref_clk_in, .nrst_in, .bc_config_in,
	.msg_ctrl_in, .attempt_done_in, .attempt_in, .retry_out, .msg_done_out, .status_out);

// ---- tb/bcmsr_top_bench.sv ----
/* Self-checking bench for bcmsr_top driven through the engine model.
   Assumes the default response-time count; inputs change on falling edges. */
`timescale 1ns/100ps
module bcmsr_top_bench
	import bcmsr_pkg::*;
;
	logic	clk = 1'b0, nrst_in = 1'b0, txok = 1'b1, start, sync, done, retry, mdone;
	logic [4:0]	cmd_addr = 5'h05;
	logic [15:0]	cfg = 16'h0000, ctrl = 16'h0000;
	bcmsr_attempt_type	att, ok, fe, sset;
	bcmsr_status_type	st;
	int	bad_count = 0, n_compared = 0;
	always #50 clk = ~clk;
	bcmsr_engine i_bcmsr_engine (.clk_in(clk), .cmd_start_out(start), .resp_sync_out(sync),
		.done_out(done), .att_out(att));
	bcmsr_top i_bcmsr_top (.ref_clk_in(clk), .nrst_in(nrst_in), .bc_config_in(cfg),
		.msg_ctrl_in(ctrl), .cmd_rt_addr_in(cmd_addr), .cmd_start_in(start), .resp_sync_in(sync),
		.tx_part_ok_in(txok), .attempt_done_in(done), .attempt_in(att), .retry_out(retry),
		.msg_done_out(mdone), .status_out(st));
	function automatic bcmsr_attempt_type mk(bcmsr_kind_type k, logic [3:0] f, logic [4:0] a,
		logic [10:0] b);
		mk = {k, f, a, b};
	endfunction : mk
	task check(input string nm, input logic [4:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	// All attempts but the last use a_f.
	task msg(input bcmsr_attempt_type a_f, a_l, input int tries, gap, input logic [4:0] exp);
		for (int i = 1; i <= tries; i++) begin
			i_bcmsr_engine.run(i < tries ? a_f : a_l, gap);
			check("retry", {4'h0, retry}, {4'h0, i < tries});
		end
		check("done", {4'h0, mdone}, 5'h01);
		check("status", st, exp);
	endtask : msg
	task print_verdict;
		if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : print_verdict
	initial begin
		ok = mk(BCMSR_KIND_RT_TO_BC, 4'h9, 5'h05, 11'h000);
		fe = mk(BCMSR_KIND_RT_TO_BC, 4'hd, 5'h05, 11'h000);
		sset = mk(BCMSR_KIND_BC_TO_RT, 4'h9, 5'h05, 11'h020);
		repeat (6) @(negedge clk);
		nrst_in = 1'b1;
		for (int k = 0; k < 6; k++)
			msg(ok, mk(bcmsr_kind_type'(k), 4'h9, 5'h05, 11'h0), 1, 45, {2'h0, 1'(6'h16 >> k), 2'h0});
		msg(ok, mk(BCMSR_KIND_RT_TO_RT, 4'hb, 5'h05, 11'h0), 1, 45, 5'h04);
		txok = 1'b0;
		msg(ok, mk(BCMSR_KIND_RT_TO_RT, 4'h9, 5'h05, 11'h0), 1, 45, 5'h00);
		txok = 1'b1;
		msg(ok, mk(BCMSR_KIND_RT_TO_BC, 4'h1, 5'h05, 11'h0), 1, 45, 5'h00);
		msg(ok, mk(BCMSR_KIND_BC_TO_RT, 4'h9, 5'h06, 11'h0), 1, 45, 5'h02);
		cmd_addr = 5'h06;
		msg(ok, mk(BCMSR_KIND_BC_TO_RT, 4'h9, 5'h06, 11'h0), 1, 45, 5'h00);
		msg(ok, mk(BCMSR_KIND_BC_TO_RT, 4'h9, 5'h05, 11'h0), 1, 45, 5'h02);
		cmd_addr = 5'h05;
		for (int g = 0; g < 3; g++) begin
			cfg = g < 2 ? 16'h0002 : 16'h0000;
			msg(ok, sset ^ 23'h20, 1, 40 - (g != 0), {3'h0, g == 1, 1'b0});
		end
		for (int m = 0; m < 2; m++) begin
			ctrl = {6'h00, m[0], 9'h000};
			msg(ok, sset, 1, 45, {4'h0, m == 0});
		end
		ctrl = 16'h0100;
		cfg = 16'h1000;
		msg(fe, fe, 3, 45, 5'h10);
		msg(fe, ok, 2, 45, 5'h0c);
		msg(sset, sset, 1, 45, 5'h01);
		cfg = 16'h1100;
		msg(sset, sset, 3, 45, 5'h11);
		ctrl = 16'h0000;
		msg(fe, fe, 1, 45, 5'h00);
		print_verdict();
	end
endmodule : bcmsr_top_bench
